// ---- core/can_phy_mode.sv ----
`timescale 1ns/10ps
`include "can_phy_consts.svh"
// mode and data path logic of an isolated can transceiver
module can_phy_mode #(
  parameter int DOM_LIMIT = `DOM_LIMIT_TICKS,
  parameter int WAKE_RESET = `WAKE_RESET_TICKS,
  parameter int WAKE_PHASE = `WAKE_PHASE_TICKS,
  parameter int BEAT_PERIOD = `BEAT_PERIOD_TICKS,
  parameter int BEAT_WIDTH = `BEAT_WIDTH_TICKS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // controller side pins
  input wire logic tx_data,
  input wire logic tx_open,
  output logic rx_data,
  input wire logic standby_request,
  input wire logic listen_only,
  input wire logic aux_in,
  // bus side
  input wire logic bus_dominant,
  output logic drive_dominant,
  output logic driver_enable,
  output logic bias_to_ground,
  input wire logic [1:0] rate_select_pin,
  input wire logic over_temp,
  output logic aux_out,
  // status
  output logic standby_pulse,
  output logic wake_seen,
  output logic dom_timeout
);
  initial begin
    if (DOM_LIMIT < 2 || WAKE_RESET < 4 || BEAT_WIDTH >= BEAT_PERIOD)
      $error("bad timing parameters");
  end

  // two-stage synchronisers for pin inputs
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic [1:0] r1_q;
  logic [1:0] r2_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q <= `PIN_SYNC_RESET; // idle levels, no false edge after reset
      s2_q <= `PIN_SYNC_RESET;
      r1_q <= `RATE_HIGH_SPEED;
      r2_q <= `RATE_HIGH_SPEED;
    end else begin
      s1_q <= {tx_data, standby_request, listen_only, aux_in,
               bus_dominant, over_temp, tx_open};
      s2_q <= s1_q;
      r1_q <= rate_select_pin;
      r2_q <= r1_q;
    end
  end
  // named synchronised pins; floating transmit reads high
  wire tx_s = s2_q[6] | s2_q[0];
  wire standby_request_s = s2_q[5];
  wire listen_s = s2_q[4];
  wire aux_s = s2_q[3];
  wire bus_dom_s = s2_q[2]; // resolved bus, dominant wins
  wire hot_s = s2_q[1];
  wire rate_standby_request = (r2_q == `RATE_STANDBY);
  wire xcvr_standby_request = standby_request_s | rate_standby_request;

  // mode priority: standby, listen, normal
  can_phy_pkg::phy_mode_t mode;
  assign mode = xcvr_standby_request ? can_phy_pkg::MODE_STANDBY :
                listen_s ? can_phy_pkg::MODE_LISTEN :
                can_phy_pkg::MODE_NORMAL;

  // dominant timeout counter
  logic [31:0] dom_cnt_q;
  logic dom_to_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dom_cnt_q <= '0;
      dom_to_q <= 1'b0;
    end else if (tx_s) begin
      dom_cnt_q <= '0; // release after high
      dom_to_q <= 1'b0;
    end else if (dom_cnt_q >= 32'(DOM_LIMIT - 1)) begin
      dom_to_q <= 1'b1;
    end else begin
      dom_cnt_q <= dom_cnt_q + 32'h0000_0001;
    end
  end

  // wake pattern detector
  can_phy_pkg::wake_state_t wst_q;
  logic [31:0] wph_q;
  logic [31:0] wtot_q;
  wire phase_ok = (wph_q >= 32'(WAKE_PHASE));
  always_ff @(posedge clk_sys) begin
    if (rst || !xcvr_standby_request) begin
      wst_q <= can_phy_pkg::WAKE_IDLE;
      wph_q <= '0;
      wtot_q <= '0;
    end else begin
      wph_q <= wph_q + 32'h0000_0001;
      if (wst_q != can_phy_pkg::WAKE_IDLE)
        wtot_q <= wtot_q + 32'h0000_0001;
      unique case (wst_q)
        can_phy_pkg::WAKE_IDLE: begin
          if (!bus_dom_s) wph_q <= '0;
          else if (phase_ok) begin
            wst_q <= can_phy_pkg::WAKE_LOW;
            wph_q <= '0;
            wtot_q <= '0;
          end
        end
        can_phy_pkg::WAKE_LOW: begin
          if (wtot_q >= 32'(WAKE_RESET)) wst_q <= can_phy_pkg::WAKE_IDLE;
          else if (bus_dom_s) wph_q <= '0;
          else if (phase_ok) begin
            wst_q <= can_phy_pkg::WAKE_HIGH;
            wph_q <= '0;
          end
        end
        can_phy_pkg::WAKE_HIGH: begin
          if (wtot_q >= 32'(WAKE_RESET)) wst_q <= can_phy_pkg::WAKE_IDLE;
          else if (!bus_dom_s) wph_q <= '0;
          else if (phase_ok) wst_q <= can_phy_pkg::WAKE_DONE;
        end
        can_phy_pkg::WAKE_DONE: begin
          wst_q <= can_phy_pkg::WAKE_DONE; // held until standby ends
        end
      endcase
    end
  end
  wire woke = (wst_q == can_phy_pkg::WAKE_DONE);

  // keep-alive pulse timer during standby
  logic [31:0] beat_q;
  always_ff @(posedge clk_sys) begin
    if (rst || !standby_request_s) beat_q <= '0;
    else if (beat_q >= 32'(BEAT_PERIOD - 1)) beat_q <= '0;
    else beat_q <= beat_q + 32'h0000_0001;
  end

  // auxiliary fifo path; drained only outside standby
  logic aux_fv;
  logic aux_fd;
  logic aux_q;
  logic aux_prev_q;
  wire aux_push = (aux_s != aux_prev_q) && !standby_request_s;
  aux_fifo #(.WIDTH(1), .DEPTH(4)) u_aux_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(aux_push),
    .in_ready(),
    .in_data(aux_s),
    .out_valid(aux_fv),
    .out_ready(!standby_request_s),
    .out_data(aux_fd)
  );
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aux_q <= `AUX_RESET_VALUE;
      aux_prev_q <= `AUX_RESET_VALUE;
    end else begin
      if (!standby_request_s) aux_prev_q <= aux_s;
      if (aux_fv && !standby_request_s) aux_q <= aux_fd;
    end
  end

  // output registers
  logic drv_q;
  logic en_q;
  logic rx_q;
  logic pulse_q;
  wire tx_allowed = (mode == can_phy_pkg::MODE_NORMAL);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      drv_q <= 1'b0;
      en_q <= 1'b0;
      rx_q <= 1'b1;
      pulse_q <= 1'b0;
    end else begin
      drv_q <= tx_allowed && !tx_s && !dom_to_q && !hot_s;
      en_q <= !xcvr_standby_request && !hot_s;
      rx_q <= (xcvr_standby_request && !woke) ? 1'b1 : !bus_dom_s;
      pulse_q <= standby_request_s && (beat_q < 32'(BEAT_WIDTH));
    end
  end
  assign drive_dominant = drv_q;
  assign driver_enable = en_q;
  assign bias_to_ground = xcvr_standby_request;
  assign rx_data = rx_q;
  assign aux_out = aux_q;
  assign standby_pulse = pulse_q;
  assign wake_seen = woke;
  assign dom_timeout = dom_to_q;

  // assertions
  a_listen_recessive: assert property (@(posedge clk_sys) disable iff (rst)
    $past(listen_s) && !$past(xcvr_standby_request) |-> !drive_dominant)
    else $error("listen-only drove dominant");
  a_standby_blocks_tx: assert property (@(posedge clk_sys) disable iff (rst)
    $past(xcvr_standby_request) |-> !drive_dominant && !driver_enable)
    else $error("standby drove bus");
  a_rx_follow_bus: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(xcvr_standby_request) |-> rx_data == !$past(bus_dom_s))
    else $error("receive not following bus");
  a_standby_rx_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    $past(xcvr_standby_request) && !$past(woke) |-> rx_data)
    else $error("standby receive leaked");
  a_aux_hold_standby_request: assert property (@(posedge clk_sys) disable iff (rst)
    standby_request_s && $past(standby_request_s) |-> $stable(aux_out))
    else $error("aux changed in standby");
  a_hot_off: assert property (@(posedge clk_sys) disable iff (rst)
    $past(hot_s) |-> !drive_dominant && !driver_enable)
    else $error("driver on while hot");
  a_timeout_release: assert property (@(posedge clk_sys) disable iff (rst)
    dom_to_q |=> !drive_dominant)
    else $error("dominant after timeout");
  a_wake_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    woke && xcvr_standby_request |=> woke)
    else $error("wake state lost in standby");
  a_pulse_only_standby_request: assert property (@(posedge clk_sys) disable iff (rst)
    standby_pulse |-> $past(standby_request_s))
    else $error("pulse outside standby");
endmodule : can_phy_mode

// ---- include/can_phy_consts.svh ----
// Behaviour
// - low transmit drives dominant; receive mirrors bus
// - dominant wins on the shared bus
// - standby blocks transmit, driver high impedance
// - standby receive silent until wake pattern
// - low-high-low within reset time wakes receive
// - wake pattern does not end standby
// - listen-only ignores transmit, holds recessive
// - listen-only receive path works normally
// - rate pin picks high speed, slope, standby (only standby is decoded; slope acts as high speed)
// - rate pin standby filters data, biases low
// - rate pin standby spares auxiliary channel
// - auxiliary passes data when not standby
// - auxiliary holds value when standby asserted
// - short keep-alive pulses during standby (only for pin standby; rate pin standby gives none)
// - floating transmit reads as recessive
// - long dominant transmit released after timeout
// - over temperature disables bus driver
// - auxiliary output low after startup
`ifndef CAN_PHY_CONSTS_SVH
`define CAN_PHY_CONSTS_SVH
// rate select pin encodings
`define RATE_HIGH_SPEED 2'h0
`define RATE_SLOPE 2'h1
`define RATE_STANDBY 2'h2
// timing defaults in clk_sys ticks
`define DOM_LIMIT_TICKS 32'h0000_C350
`define WAKE_RESET_TICKS 32'h0004_C4B4
`define WAKE_PHASE_TICKS 32'h0000_0096
`define BEAT_PERIOD_TICKS 32'h0000_2710
`define BEAT_WIDTH_TICKS 32'h0000_03E8
`define AUX_RESET_VALUE 1'h0
// synchroniser idle: transmit recessive, every other pin low
`define PIN_SYNC_RESET 7'h40
`endif

// ---- include/can_phy_pkg.sv ----
package can_phy_pkg;
  // transceiver operating modes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_LISTEN = 2'b01,
    MODE_STANDBY = 2'b10
  } phy_mode_t;
  // wake pattern detector states
  typedef enum logic [1:0] {
    WAKE_IDLE = 2'b00,
    WAKE_LOW = 2'b01,
    WAKE_HIGH = 2'b10,
    WAKE_DONE = 2'b11
  } wake_state_t;
endpackage : can_phy_pkg

// ---- core/aux_fifo.sv ----
`timescale 1ns/10ps
// small valid/ready fifo for the auxiliary data path
module aux_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be power of 2");
  end
  // storage array
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rd_q[AW-1:0]];
  // pointer update
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
  // data write
  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule : aux_fifo

// ---- testbench/can_ctrl_model.sv ----
`timescale 1ns/10ps
// logic side controller: sends bits, backs off on lost arbitration
module can_ctrl_model #(
  // edges from a transmit change until it shows on receive
  parameter int LOOP_TICKS = 6
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bench control
  input wire logic send_bit,
  input wire logic quiet,
  // transceiver pins
  input wire logic rx_data,
  output logic tx_data,
  output logic lost
);
  initial begin
    if (LOOP_TICKS < 1 || LOOP_TICKS > 15) $error("loop delay out of range");
  end
  // cycles that transmit has stood recessive, saturating
  logic [3:0] rec_q;
  always_ff @(posedge clk_sys) begin
    if (rst || !tx_data) rec_q <= 4'h0;
    else if (rec_q != 4'hf) rec_q <= rec_q + 4'h1;
  end
  // dominant read once own recessive has looped back: give up until free
  always_ff @(posedge clk_sys) begin
    if (rst || rx_data) lost <= 1'h0;
    else if (send_bit && rec_q >= 4'(LOOP_TICKS)) lost <= 1'h1;
  end
  // recessive while settling a standby change or after losing
  assign tx_data = send_bit | quiet | lost;
endmodule : can_ctrl_model

// ---- testbench/test_can_phy_mode.sv ----
`timescale 1ns/10ps
// bench for the transceiver mode logic
module test_can_phy_mode;
  logic clk_sys, rst, send_bit, quiet, tx_open, standby_request;
  logic listen_only, aux_in, other_dom, over_temp;
  logic [1:0] rate_select_pin;
  logic tx_data, rx_data, drive_dominant, driver_enable, bias_to_ground;
  logic aux_out, standby_pulse, wake_seen, dom_timeout, lost;
  int err_total = 0;
  int compares = 0;
  int n, w;
  // shared bus: any dominant wins
  wire bus_dominant = (drive_dominant & driver_enable) | other_dom;
  can_phy_mode #(.DOM_LIMIT(20), .WAKE_RESET(200), .WAKE_PHASE(4),
    .BEAT_PERIOD(20), .BEAT_WIDTH(3)) u_can_phy_mode (
    .clk_sys(clk_sys), .rst(rst), .tx_data(tx_data), .tx_open(tx_open),
    .rx_data(rx_data), .standby_request(standby_request),
    .listen_only(listen_only), .aux_in(aux_in),
    .bus_dominant(bus_dominant), .drive_dominant(drive_dominant),
    .driver_enable(driver_enable), .bias_to_ground(bias_to_ground),
    .rate_select_pin(rate_select_pin), .over_temp(over_temp),
    .aux_out(aux_out), .standby_pulse(standby_pulse),
    .wake_seen(wake_seen), .dom_timeout(dom_timeout));
  can_ctrl_model u_can_ctrl_model (.clk_sys(clk_sys), .rst(rst),
    .send_bit(send_bit), .quiet(quiet), .rx_data(rx_data),
    .tx_data(tx_data), .lost(lost));
  // free running clock
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // wait edges; reads after return see settled pre-edge values
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : tick
  // one bit compare
  task automatic chk(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %b expected %b", $time, got, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    rst = 1'h1; send_bit = 1'h1; quiet = 1'h0; tx_open = 1'h0;
    standby_request = 1'h0; listen_only = 1'h0; aux_in = 1'h0;
    other_dom = 1'h0; over_temp = 1'h0; rate_select_pin = 2'h0;
    tick(6);
    chk(aux_out, 1'h0);
    rst <= 1'h0;
    tick(5);
    // every rate pin code, aux must ignore rate standby
    for (int i = 0; i < 4; i++) begin
      rate_select_pin <= i[1:0];
      send_bit <= 1'h0;
      aux_in <= i[1];
      tick(8);
      chk(drive_dominant, i != 2);
      chk(bias_to_ground, i == 2);
      chk(rx_data, i == 2);
      chk(aux_out, i[1]);
      send_bit <= 1'h1;
      tick(5);
    end
    rate_select_pin <= 2'h0;
    // another node wins arbitration
    other_dom <= 1'h1;
    tick(5);
    chk(rx_data, 1'h0);
    chk(lost, 1'h1);
    other_dom <= 1'h0;
    tick(5);
    chk(rx_data, 1'h1);
    // listen only
    listen_only <= 1'h1;
    send_bit <= 1'h0;
    tick(5);
    chk(drive_dominant, 1'h0);
    other_dom <= 1'h1;
    tick(5);
    chk(rx_data, 1'h0);
    other_dom <= 1'h0;
    listen_only <= 1'h0;
    send_bit <= 1'h1;
    tick(5);
    // floating transmit, then over temperature
    tx_open <= 1'h1;
    send_bit <= 1'h0;
    tick(5);
    chk(drive_dominant, 1'h0);
    tx_open <= 1'h0;
    over_temp <= 1'h1;
    tick(5);
    chk(driver_enable, 1'h0);
    over_temp <= 1'h0;
    tick(5);
    chk(drive_dominant & driver_enable, 1'h1);
    // held dominant past the limit
    tick(20);
    chk(dom_timeout, 1'h1);
    chk(drive_dominant, 1'h0);
    send_bit <= 1'h1;
    tick(5);
    chk(dom_timeout, 1'h0);
    send_bit <= 1'h0;
    tick(5);
    chk(drive_dominant, 1'h1);
    send_bit <= 1'h1;
    // enter standby with aux high
    quiet <= 1'h1;
    standby_request <= 1'h1;
    tick(5);
    aux_in <= 1'h0;
    quiet <= 1'h0;
    send_bit <= 1'h0;
    tick(8);
    chk(aux_out, 1'h1);
    chk(driver_enable | drive_dominant, 1'h0);
    chk(bias_to_ground, 1'h1);
    send_bit <= 1'h1;
    // keep-alive pulse, bounded wait and width
    n = 0;
    while (standby_pulse !== 1'h1 && n < 60) begin
      tick(1);
      n++;
    end
    w = 0;
    while (standby_pulse === 1'h1 && w < 10) begin
      tick(1);
      w++;
    end
    chk(n < 60 && w > 0 && w <= 3, 1'h1);
    // a wait that ran out ends the run as a failure
    if (n >= 60 || w >= 10) begin
      err_total++;
      $display("[FAIL] %0t keep-alive wait ran out", $time);
      final_report();
    end
    // dominant filtered, then wake pattern
    other_dom <= 1'h1;
    tick(6);
    chk(rx_data, 1'h1);
    other_dom <= 1'h0;
    tick(6);
    other_dom <= 1'h1;
    tick(6);
    other_dom <= 1'h0;
    tick(6);
    chk(wake_seen, 1'h1);
    other_dom <= 1'h1;
    tick(5);
    chk(rx_data, 1'h0);
    other_dom <= 1'h0;
    tick(30);
    chk(wake_seen & bias_to_ground, 1'h1);
    // leave standby
    quiet <= 1'h1;
    standby_request <= 1'h0;
    tick(8);
    chk(wake_seen, 1'h0);
    chk(aux_out, 1'h0);
    quiet <= 1'h0;
    send_bit <= 1'h0;
    tick(5);
    chk(drive_dominant, 1'h1);
    send_bit <= 1'h1;
    tick(5);
    final_report();
  end
endmodule : test_can_phy_mode
